// >>> core/ballast_pkg.sv
package ballast_pkg;
	localparam int unsigned CLK_HZ      = 100_000_000;
	localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
	localparam int unsigned CYC_PER_US  = CLK_HZ / 1_000_000;
	// Times as printed
	localparam int unsigned PRERUN_MS   = 625;
	localparam int unsigned RESTART_MS  = 200;
	localparam int unsigned UV_LONG_MS  = 800;
	localparam int unsigned RECTIFIER_EFFECT_FAULT_MS     = 2500;
	localparam int unsigned LAMP_OVERVOLTAGE_FAULT_US     = 620;
	localparam int unsigned CAP_US      = 620;
	localparam int unsigned UV_QUAL_US  = 84;
	localparam int unsigned DT_QUAL_NS  = 280;
	localparam int unsigned DT_MIN_NS   = 1050;
	localparam int unsigned DT_MAX_NS   = 2000;
	// Derived cycle counts
	localparam int unsigned PRERUN_CYC  = PRERUN_MS * CYC_PER_MS;
	localparam int unsigned RESTART_CYC = RESTART_MS * CYC_PER_MS;
	localparam int unsigned UV_LONG_CYC = UV_LONG_MS * CYC_PER_MS;
	localparam int unsigned RECTIFIER_EFFECT_FAULT_CYC    = RECTIFIER_EFFECT_FAULT_MS * CYC_PER_MS;
	localparam int unsigned LAMP_OVERVOLTAGE_FAULT_CYC    = LAMP_OVERVOLTAGE_FAULT_US * CYC_PER_US;
	localparam int unsigned CAP_CYC     = CAP_US * CYC_PER_US;
	localparam int unsigned UV_QUAL_CYC = UV_QUAL_US * CYC_PER_US;
	localparam int unsigned DT_QUAL_CYC = (DT_QUAL_NS * CYC_PER_US + 999) / 1000;
	localparam int unsigned DT_MIN_CYC  = (DT_MIN_NS * CYC_PER_US + 999) / 1000;
	localparam int unsigned DT_MAX_CYC  = (DT_MAX_NS * CYC_PER_US) / 1000;
	localparam int TMR_W = 28;
	// Register map
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_DEADTIME = 8'h08;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam int ST_LAMP_OVERVOLTAGE_FAULT_BIT  = 0;
	localparam int ST_RECTIFIER_EFFECT_FAULT_BIT  = 1;
	localparam int ST_CAP_BIT   = 2;
	localparam int ST_UVS_BIT   = 3;
	localparam int ST_UVL_BIT   = 4;
	localparam int ST_RUSED_BIT = 5;
	localparam int ST_LATCH_BIT = 6;
	localparam int ST_RUN_BIT   = 7;
	typedef enum logic [2:0] {
		ST_OFF, ST_START, ST_PRERUN, ST_RUN, ST_RESTART, ST_LATCHED, ST_UV_LATCH
	} run_state_type;
	typedef enum logic [2:0] {
		HB_IDLE, HB_HS_ON, HB_DT_MEAS, HB_LS_ON, HB_DT_WAIT
	} hb_state_type;
endpackage

// >>> core/lamp_ballast_fault_supervisor.sv
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module qual_timer #(
	parameter int unsigned LIMIT = 1
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_en,
	input  wire logic i_flag,
	output logic      o_hit
);
	typedef struct packed {
		logic [ballast_pkg::TMR_W-1:0] cnt;
	} qstate_type;
	qstate_type s_q;
	qstate_type s_d;
	localparam logic [ballast_pkg::TMR_W-1:0] LIM = ballast_pkg::TMR_W'(LIMIT);

	always_comb begin
		s_d = s_q;
		if (i_en && i_flag) begin
			if (s_q.cnt != LIM)
				s_d.cnt = s_q.cnt + 1'b1;
		end else begin
			s_d.cnt = '0;
		end
	end

	// Hit once held for more than LIMIT cycles
	assign o_hit = i_en && i_flag && (s_q.cnt == LIM);

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

module lamp_ballast_fault_supervisor #(
	parameter int unsigned P_PRERUN_CYC  = ballast_pkg::PRERUN_CYC,
	parameter int unsigned P_RESTART_CYC = ballast_pkg::RESTART_CYC,
	parameter int unsigned P_UV_LONG_CYC = ballast_pkg::UV_LONG_CYC,
	parameter int unsigned P_RECTIFIER_EFFECT_FAULT_CYC    = ballast_pkg::RECTIFIER_EFFECT_FAULT_CYC,
	parameter int unsigned P_LAMP_OVERVOLTAGE_FAULT_CYC    = ballast_pkg::LAMP_OVERVOLTAGE_FAULT_CYC,
	parameter int unsigned P_CAP_CYC     = ballast_pkg::CAP_CYC,
	parameter int unsigned P_UV_QUAL_CYC = ballast_pkg::UV_QUAL_CYC
) (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_sys_rst,
	// APB slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Comparator flags
	input  wire logic        i_pfc_current_sense_over,
	input  wire logic        i_pfc_zero_current_input,
	input  wire logic        i_lamp_ac_over,
	input  wire logic        i_lamp_dc_over,
	input  wire logic        i_low_side_current_sense_neg,
	input  wire logic        i_low_side_current_sense_high,
	input  wire logic        i_bus_voltage_sense_below_75,
	input  wire logic        i_bus_voltage_sense_above_12p5,
	input  wire logic        i_lamp_sense_above_18ua,
	// Sequence events
	input  wire logic        i_run_freq_reached,
	input  wire logic        i_lamp_inserted,
	input  wire logic        i_supply_interrupted,
	input  wire logic        i_pfc_start,
	input  wire logic [11:0] i_ontime_cyc,
	input  wire logic [7:0]  i_ext_cyc,
	input  wire logic        i_hs_off_req,
	input  wire logic        i_ls_off_req,
	// Drivers and status
	output logic             o_pfc_gate,
	output logic             o_hs_gate,
	output logic             o_ls_gate,
	output logic             o_restart,
	output logic             o_full_restart,
	output logic             o_skip_preheat,
	output logic             o_lamp_overvoltage_fault,
	output logic             o_rectifier_effect_fault,
	output logic             o_capacitive_overcurrent_fault,
	output logic             o_uv_short,
	output logic             o_uv_long
);
	localparam int TW = ballast_pkg::TMR_W;
	localparam logic [7:0] DT_MIN  = 8'(ballast_pkg::DT_MIN_CYC);
	localparam logic [7:0] DT_MAX  = 8'(ballast_pkg::DT_MAX_CYC);
	localparam logic [4:0] DT_QUAL = 5'(ballast_pkg::DT_QUAL_CYC);

	typedef struct packed {
		ballast_pkg::run_state_type st;
		ballast_pkg::hb_state_type  hb;
		logic          ctrl_en;
		logic          restart_used;
		logic          lamp_overvoltage_fault;
		logic          rectifier_effect_fault;
		logic          cap;
		logic          uv_short;
		logic          uv_long;
		logic          skip_ph;
		logic          restart;
		logic          full_restart;
		logic [TW-1:0] wait_cnt;
		logic [TW-1:0] uv_cnt;
		logic          pfc_gate;
		logic          pfc_wait_zcd;
		logic [12:0]   pfc_cnt;
		logic          hs_gate;
		logic          ls_gate;
		logic [7:0]    dt_cnt;
		logic [4:0]    neg_cnt;
		logic [7:0]    dt_store;
		logic          cap_pre;
		logic          cap_acc;
		logic          hs_edge;
		logic          cap_present;
		logic [31:0]   prdata;
	} state_type;

	state_type s_q;
	state_type s_d;
	logic lamp_overvoltage_fault_hit;
	logic rectifier_effect_fault_hit;
	logic cap_hit;
	logic uv_hit;
	logic in_run;
	logic drv_ok;
	logic fault;
	logic [12:0] pfc_sum;
	logic apb_setup;
	logic apb_access;
	logic addr_ok;

	assign in_run  = (s_q.st == ballast_pkg::ST_RUN);
	assign pfc_sum = {1'b0, i_ontime_cyc} + {5'h00, i_ext_cyc};
	assign fault   = lamp_overvoltage_fault_hit || rectifier_effect_fault_hit || cap_hit;

	// Detectors stay cleared outside run, so pre-run cannot trip them
	qual_timer #(.LIMIT(P_LAMP_OVERVOLTAGE_FAULT_CYC)) u_lamp_overvoltage_fault (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(in_run),
		.i_flag(i_lamp_ac_over), .o_hit(lamp_overvoltage_fault_hit));
	qual_timer #(.LIMIT(P_RECTIFIER_EFFECT_FAULT_CYC)) u_rectifier_effect_fault (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(in_run),
		.i_flag(i_lamp_dc_over), .o_hit(rectifier_effect_fault_hit));
	qual_timer #(.LIMIT(P_CAP_CYC)) u_cap (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(in_run),
		.i_flag(s_q.cap_present), .o_hit(cap_hit));
	qual_timer #(.LIMIT(P_UV_QUAL_CYC)) u_uvq (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(in_run),
		.i_flag(i_bus_voltage_sense_below_75), .o_hit(uv_hit));

	assign apb_setup  = i_psel && !i_penable;
	assign apb_access = i_psel && i_penable;
	assign addr_ok    = (i_paddr == ballast_pkg::ADDR_CTRL) || (i_paddr == ballast_pkg::ADDR_STATUS)
		|| (i_paddr == ballast_pkg::ADDR_DEADTIME);
	assign o_pready   = 1'b1;
	assign o_pslverr  = apb_access && !addr_ok;

	always_comb begin
		s_d = s_q;
		s_d.restart = 1'b0;
		s_d.full_restart = 1'b0;
		// Sequencer
		case (s_q.st)
			ballast_pkg::ST_OFF: begin
				s_d.st = ballast_pkg::ST_START;
			end
			ballast_pkg::ST_START: begin
				if (i_run_freq_reached) begin
					s_d.st = ballast_pkg::ST_PRERUN;
					s_d.wait_cnt = '0;
				end
			end
			ballast_pkg::ST_PRERUN: begin
				s_d.wait_cnt = s_q.wait_cnt + 1'b1;
				if (s_q.wait_cnt >= TW'(P_PRERUN_CYC - 1)) begin
					s_d.st = ballast_pkg::ST_RUN;
					s_d.uv_cnt = '0;
					s_d.skip_ph = 1'b0;
				end
			end
			ballast_pkg::ST_RUN: begin
				if (fault) begin
					if (lamp_overvoltage_fault_hit)
						s_d.lamp_overvoltage_fault = 1'b1;
					if (rectifier_effect_fault_hit)
						s_d.rectifier_effect_fault = 1'b1;
					if (cap_hit)
						s_d.cap = 1'b1;
					s_d.wait_cnt = '0;
					if (s_q.restart_used) begin
						s_d.st = ballast_pkg::ST_LATCHED;
					end else begin
						s_d.restart_used = 1'b1;
						s_d.st = ballast_pkg::ST_RESTART;
					end
				end else if (uv_hit) begin
					s_d.st = ballast_pkg::ST_UV_LATCH;
				end
			end
			ballast_pkg::ST_RESTART: begin
				s_d.wait_cnt = s_q.wait_cnt + 1'b1;
				if (s_q.wait_cnt >= TW'(P_RESTART_CYC - 1)) begin
					s_d.st = ballast_pkg::ST_START;
					s_d.restart = 1'b1;
				end
			end
			ballast_pkg::ST_LATCHED: begin
				// Only a lamp change, a supply interruption or a cleared ctrl_en releases the latch
				if (i_lamp_inserted || i_supply_interrupted) begin
					s_d.lamp_overvoltage_fault = 1'b0;
					s_d.rectifier_effect_fault = 1'b0;
					s_d.cap = 1'b0;
					s_d.restart_used = 1'b0;
					s_d.st = ballast_pkg::ST_START;
					s_d.restart = 1'b1;
				end
			end
			ballast_pkg::ST_UV_LATCH: begin
				if (i_bus_voltage_sense_below_75)
					s_d.uv_cnt = s_q.uv_cnt + 1'b1;
				if (s_q.uv_cnt >= TW'(P_UV_LONG_CYC)) begin
					s_d.uv_long = 1'b1;
					s_d.full_restart = 1'b1;
					s_d.skip_ph = 1'b0;
					s_d.restart_used = 1'b0;
					s_d.st = ballast_pkg::ST_START;
				end else if (!i_bus_voltage_sense_below_75 && i_lamp_sense_above_18ua
					&& i_bus_voltage_sense_above_12p5) begin
					// Short term is only decided once the bus has come back
					s_d.uv_short = 1'b1;
					s_d.skip_ph = 1'b1;
					s_d.restart = 1'b1;
					s_d.st = ballast_pkg::ST_START;
				end
			end
			default: begin
				s_d.st = ballast_pkg::ST_OFF;
			end
		endcase
		if (!s_q.ctrl_en)
			s_d.st = ballast_pkg::ST_OFF;
		drv_ok = (s_d.st == ballast_pkg::ST_START) || (s_d.st == ballast_pkg::ST_PRERUN)
			|| (s_d.st == ballast_pkg::ST_RUN);

		// PFC gate
		if (s_q.pfc_gate) begin
			s_d.pfc_cnt = s_q.pfc_cnt - 1'b1;
			if (i_pfc_current_sense_over) begin
				s_d.pfc_gate = 1'b0;
				s_d.pfc_wait_zcd = 1'b1;
			end else if (s_q.pfc_cnt <= 13'h0001) begin
				s_d.pfc_gate = 1'b0;
			end
		end else if (i_pfc_start && !s_q.pfc_wait_zcd && pfc_sum != 13'h0000) begin
			s_d.pfc_gate = 1'b1;
			s_d.pfc_cnt = pfc_sum;
		end
		// Zero-current event after the cut releases the wait
		if (!s_q.pfc_gate && i_pfc_zero_current_input)
			s_d.pfc_wait_zcd = 1'b0;
		if (!drv_ok) begin
			s_d.pfc_gate = 1'b0;
			s_d.pfc_wait_zcd = 1'b0;
		end

		// Half bridge
		case (s_q.hb)
			ballast_pkg::HB_IDLE: begin
				s_d.hb = ballast_pkg::HB_DT_WAIT;
				s_d.dt_cnt = '0;
			end
			ballast_pkg::HB_HS_ON: begin
				s_d.hs_edge = 1'b0;
				if (s_q.hs_edge && i_low_side_current_sense_high)
					s_d.cap_acc = 1'b1;
				if (i_hs_off_req) begin
					s_d.cap_present = s_q.cap_pre || s_d.cap_acc;
					s_d.cap_pre = 1'b0;
					s_d.cap_acc = 1'b0;
					s_d.hb = ballast_pkg::HB_DT_MEAS;
					s_d.dt_cnt = '0;
					s_d.neg_cnt = '0;
				end
			end
			ballast_pkg::HB_DT_MEAS: begin
				s_d.dt_cnt = s_q.dt_cnt + 1'b1;
				if (!i_low_side_current_sense_neg)
					s_d.neg_cnt = '0;
				else if (s_q.neg_cnt != DT_QUAL)
					s_d.neg_cnt = s_q.neg_cnt + 1'b1;
				// Short measurements wait out the minimum, long ones are cut at the maximum
				if ((s_q.neg_cnt == DT_QUAL && s_q.dt_cnt >= DT_MIN - 8'h01)
					|| s_q.dt_cnt >= DT_MAX - 8'h01) begin
					s_d.dt_store = s_q.dt_cnt + 1'b1;
					s_d.hb = ballast_pkg::HB_LS_ON;
				end
			end
			ballast_pkg::HB_LS_ON: begin
				if (i_ls_off_req) begin
					s_d.hb = ballast_pkg::HB_DT_WAIT;
					s_d.dt_cnt = '0;
				end
			end
			ballast_pkg::HB_DT_WAIT: begin
				s_d.dt_cnt = s_q.dt_cnt + 1'b1;
				if (s_q.dt_cnt >= s_q.dt_store - 8'h01) begin
					s_d.cap_pre = i_low_side_current_sense_neg;
					s_d.hs_edge = 1'b1;
					s_d.hb = ballast_pkg::HB_HS_ON;
				end
			end
			default: begin
				s_d.hb = ballast_pkg::HB_IDLE;
			end
		endcase
		if (!drv_ok) begin
			s_d.hb = ballast_pkg::HB_IDLE;
			s_d.cap_pre = 1'b0;
			s_d.cap_acc = 1'b0;
			s_d.cap_present = 1'b0;
		end
		s_d.hs_gate = (s_d.hb == ballast_pkg::HB_HS_ON);
		s_d.ls_gate = (s_d.hb == ballast_pkg::HB_LS_ON);

		// Register access; read data is captured in setup for a zero-wait access
		if (apb_access && i_pwrite && i_paddr == ballast_pkg::ADDR_CTRL)
			s_d.ctrl_en = i_pwdata[ballast_pkg::CTRL_EN_BIT];
		s_d.prdata = '0;
		if (apb_setup && !i_pwrite) begin
			case (i_paddr)
				ballast_pkg::ADDR_CTRL:
					s_d.prdata[ballast_pkg::CTRL_EN_BIT] = s_q.ctrl_en;
				ballast_pkg::ADDR_STATUS: begin
					s_d.prdata[ballast_pkg::ST_LAMP_OVERVOLTAGE_FAULT_BIT]  = s_q.lamp_overvoltage_fault;
					s_d.prdata[ballast_pkg::ST_RECTIFIER_EFFECT_FAULT_BIT]  = s_q.rectifier_effect_fault;
					s_d.prdata[ballast_pkg::ST_CAP_BIT]   = s_q.cap;
					s_d.prdata[ballast_pkg::ST_UVS_BIT]   = s_q.uv_short;
					s_d.prdata[ballast_pkg::ST_UVL_BIT]   = s_q.uv_long;
					s_d.prdata[ballast_pkg::ST_RUSED_BIT] = s_q.restart_used;
					s_d.prdata[ballast_pkg::ST_LATCH_BIT] = (s_q.st == ballast_pkg::ST_LATCHED)
						|| (s_q.st == ballast_pkg::ST_UV_LATCH);
					s_d.prdata[ballast_pkg::ST_RUN_BIT]   = in_run;
				end
				ballast_pkg::ADDR_DEADTIME:
					s_d.prdata[7:0] = s_q.dt_store;
				default:
					s_d.prdata = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s_q <= '0;
			s_q.ctrl_en <= ballast_pkg::CTRL_EN_RST;
			s_q.dt_store <= DT_MAX;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_prdata = s_q.prdata;
	assign o_pfc_gate = s_q.pfc_gate;
	assign o_hs_gate = s_q.hs_gate;
	assign o_ls_gate = s_q.ls_gate;
	assign o_restart = s_q.restart;
	assign o_full_restart = s_q.full_restart;
	assign o_skip_preheat = s_q.skip_ph;
	assign o_lamp_overvoltage_fault = s_q.lamp_overvoltage_fault;
	assign o_rectifier_effect_fault = s_q.rectifier_effect_fault;
	assign o_capacitive_overcurrent_fault = s_q.cap;
	assign o_uv_short = s_q.uv_short;
	assign o_uv_long = s_q.uv_long;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);

	chk_cs_cuts_gate: assert property (
		o_pfc_gate && i_pfc_current_sense_over |=> !o_pfc_gate ##0 s_q.pfc_wait_zcd)
		else $error("PFC on-time not ended by overcurrent");
	chk_wait_zcd: assert property (
		s_q.pfc_wait_zcd && !i_pfc_zero_current_input |=> !o_pfc_gate)
		else $error("PFC restarted before zero-current event");
	chk_pfc_width: assert property (
		$rose(o_pfc_gate) |-> s_q.pfc_cnt == $past(pfc_sum))
		else $error("PFC pulse not loop time plus extension");
	chk_prerun_len: assert property (
		in_run && $past(s_q.st) == ballast_pkg::ST_PRERUN |-> $past(s_q.wait_cnt) == TW'(P_PRERUN_CYC - 1))
		else $error("Pre-run length wrong");
	chk_eol_run_only: assert property (
		(lamp_overvoltage_fault_hit || rectifier_effect_fault_hit) |-> in_run)
		else $error("End-of-life detected outside run");
	chk_restart_once: assert property (
		$rose(s_q.st == ballast_pkg::ST_LATCHED) |-> $past(s_q.restart_used))
		else $error("Latched without a restart attempt");
	chk_dt_range: assert property (
		s_q.dt_store >= DT_MIN && s_q.dt_store <= DT_MAX)
		else $error("Stored dead time out of range");
	chk_hs_after_dt: assert property (
		$rose(o_hs_gate) |-> $past(s_q.hb) == ballast_pkg::HB_DT_WAIT
			&& $past(s_q.dt_cnt) == s_q.dt_store - 8'h01)
		else $error("High side on before stored dead time");
	chk_ls_qualified: assert property (
		$rose(o_ls_gate) |-> $past(s_q.neg_cnt) == DT_QUAL || $past(s_q.dt_cnt) == DT_MAX - 8'h01)
		else $error("Low side on without qualified sense");
	chk_uv_drivers_off: assert property (
		s_q.st == ballast_pkg::ST_UV_LATCH |-> !o_pfc_gate && !o_hs_gate && !o_ls_gate)
		else $error("Drivers active during undervoltage latch");
	chk_run_uv_clear: assert property (
		in_run && $past(s_q.st) != ballast_pkg::ST_RUN |-> s_q.uv_cnt == '0)
		else $error("Undervoltage timer not cleared in run");
	chk_long_uv: assert property (
		$rose(o_uv_long) |-> o_full_restart && $past(s_q.uv_cnt) >= TW'(P_UV_LONG_CYC))
		else $error("Long undervoltage classed early");

	cov_latched: cover property ($rose(s_q.st == ballast_pkg::ST_LATCHED));
	cov_uv_short: cover property ($rose(o_uv_short));
	cov_cap: cover property ($rose(o_capacitive_overcurrent_fault));
	cov_dead_time: cover property ($rose(o_hs_gate));
endmodule

`default_nettype wire

// >>> test/power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
	// Clock
	input  wire logic       i_clk,
	// Gate drives and answer speed
	input  wire logic       i_hs_gate,
	input  wire logic       i_ls_gate,
	input  wire logic       i_pfc_gate,
	input  wire logic [1:0] i_mode,
	// Sense flags
	output logic            o_ls_neg,
	output logic            o_zcd
);
	logic [7:0] hs_cnt_q  = 8'h00;
	logic [7:0] zcd_cnt_q = 8'h00;
	logic       armed_q   = 1'b0;
	logic [7:0] dly;

	// Mode 2 never commutates, so the bridge has to fall back on its longest wait
	assign dly = (i_mode == 2'h0) ? 8'h02 : (i_mode == 2'h1) ? 8'h96 : 8'hFF;

	always_ff @(posedge i_clk) begin
		armed_q   <= i_hs_gate ? 1'b1 : (i_ls_gate ? 1'b0 : armed_q);
		hs_cnt_q  <= i_hs_gate ? 8'h00 : ((hs_cnt_q == 8'hFF) ? hs_cnt_q : hs_cnt_q + 8'h01);
		zcd_cnt_q <= i_pfc_gate ? 8'h00 : ((zcd_cnt_q == 8'hFF) ? zcd_cnt_q : zcd_cnt_q + 8'h01);
	end

	// Body diode conducts only between high-side off and low-side on
	assign o_ls_neg = armed_q && !i_hs_gate && !i_ls_gate && (hs_cnt_q >= dly) && (dly != 8'hFF);
	// Demagnetisation ends a fixed while after the switch opens
	assign o_zcd    = !i_pfc_gate && (zcd_cnt_q == 8'h28);
endmodule

`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e))
`define WAIT_FOR(c, l) \
	n = 0; \
	do begin \
		@(negedge i_clk); \
		n++; \
	end while (!(c) && n < (l));

module tb;
	localparam int unsigned RST  = 50;
	localparam int unsigned UVL  = 200;
	localparam int unsigned LAMP_OVERVOLTAGE_FAULT = 20;

	logic        i_clk = 1'b0, i_sys_rst = 1'b1, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00, i_ext_cyc = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd, dt;
	logic [11:0] i_ontime_cyc = 12'h000;
	logic        i_pfc_current_sense_over = 1'b0, i_lamp_ac_over = 1'b0, i_lamp_dc_over = 1'b0;
	logic        i_low_side_current_sense_high = 1'b0, i_bus_voltage_sense_below_75 = 1'b0;
	logic        i_bus_voltage_sense_above_12p5 = 1'b1, i_lamp_sense_above_18ua = 1'b1;
	logic        i_run_freq_reached = 1'b0, i_lamp_inserted = 1'b0, i_supply_interrupted = 1'b0;
	logic        i_pfc_start = 1'b0, i_hs_off_req = 1'b0, i_ls_off_req = 1'b0;
	logic        o_pready, o_pslverr, o_pfc_gate, o_hs_gate, o_ls_gate, o_restart, o_full_restart;
	logic        o_skip_preheat, o_lamp_overvoltage_fault, o_rectifier_effect_fault;
	logic        o_capacitive_overcurrent_fault, o_uv_short, o_uv_long, err, rdy;
	wire logic   i_low_side_current_sense_neg, i_pfc_zero_current_input;
	logic [1:0]  hb_mode = 2'h0;
	int          n, failures = 0, tests_run = 0, cyc = 0;

	typedef struct packed {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] r;
		logic        e;
	} apb_row_type;
	apb_row_type apb_rows [5] = '{'{1'b0, 8'h00, 32'h0, 32'h1, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'hC8, 1'b0},
		'{1'b1, 8'h08, 32'h55, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'hC8, 1'b0},
		'{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1}};
	typedef struct packed {
		logic [11:0] on;
		logic [7:0]  ext;
		logic [12:0] w;
	} pfc_row_type;
	pfc_row_type pfc_rows [4] = '{'{12'h003, 8'h01, 13'h0004}, '{12'h001, 8'h00, 13'h0001},
		'{12'h000, 8'h05, 13'h0005}, '{12'h014, 8'h1E, 13'h0032}};

	lamp_ballast_fault_supervisor #(.P_PRERUN_CYC(100), .P_RESTART_CYC(RST), .P_UV_LONG_CYC(UVL),
		.P_RECTIFIER_EFFECT_FAULT_CYC(100), .P_LAMP_OVERVOLTAGE_FAULT_CYC(LAMP_OVERVOLTAGE_FAULT), .P_CAP_CYC(20), .P_UV_QUAL_CYC(10)) u_dut (.*);

	power_stage_model u_stage (
		.i_clk      (i_clk),
		.i_hs_gate  (o_hs_gate),
		.i_ls_gate  (o_ls_gate),
		.i_pfc_gate (o_pfc_gate),
		.i_mode     (hb_mode),
		.o_ls_neg   (i_low_side_current_sense_neg),
		.o_zcd      (i_pfc_zero_current_input)
	);

	initial begin
		forever #5 i_clk = ~i_clk;
	end

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_psel    <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite  <= wr;
		i_paddr   <= a;
		i_pwdata  <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		// Answer taken at the rising edge that samples pready high, before the slave updates
		do begin
			@(posedge i_clk);
			rdy = o_pready;
		end while (rdy !== 1'b1);
		rd  = o_prdata;
		err = o_pslverr;
		i_psel    <= 1'b0;
		i_penable <= 1'b0;
	endtask

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end

	initial begin
		@(negedge i_clk);
		`CHK({o_pready, o_pfc_gate, o_hs_gate, o_ls_gate, o_restart, o_uv_long}, 32'h20);
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		foreach (apb_rows[i]) begin
			apb(apb_rows[i].wr, apb_rows[i].a, apb_rows[i].d);
			`CHK(err, apb_rows[i].e);
			if (!apb_rows[i].wr) `CHK(rd, apb_rows[i].r);
		end
		foreach (pfc_rows[i]) begin
			@(posedge i_clk);
			i_pfc_start  <= 1'b1;
			i_ontime_cyc <= pfc_rows[i].on;
			i_ext_cyc    <= pfc_rows[i].ext;
			@(posedge i_clk);
			i_pfc_start <= 1'b0;
			`WAIT_FOR(o_pfc_gate, 4)
			`WAIT_FOR(!o_pfc_gate, 400)
			`CHK(n, pfc_rows[i].w);
		end
		// Overcurrent cut, then starts refused until the next zero-current event
		@(posedge i_clk);
		i_pfc_start  <= 1'b1;
		i_ontime_cyc <= 12'h0C8;
		@(posedge i_clk);
		i_pfc_start <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_pfc_current_sense_over <= 1'b1;
		`WAIT_FOR(!o_pfc_gate, 4)
		`CHK(n <= 2, 1);
		@(posedge i_clk);
		i_pfc_current_sense_over <= 1'b0;
		i_pfc_start              <= 1'b1;
		@(posedge i_clk);
		i_pfc_start <= 1'b0;
		`WAIT_FOR(o_pfc_gate, 10)
		`CHK(o_pfc_gate, 0);
		`WAIT_FOR(i_pfc_zero_current_input, 60)
		@(posedge i_clk);
		i_pfc_start <= 1'b1;
		@(posedge i_clk);
		i_pfc_start <= 1'b0;
		`WAIT_FOR(o_pfc_gate, 4)
		`CHK(o_pfc_gate, 1);
		`WAIT_FOR(!o_pfc_gate, 300)
		// Prompt, slow and missing commutation
		for (int m = 0; m < 3; m++) begin
			@(posedge i_clk);
			hb_mode <= 2'(m);
			`WAIT_FOR(o_hs_gate, 400)
			@(posedge i_clk);
			i_hs_off_req <= 1'b1;
			@(posedge i_clk);
			i_hs_off_req <= 1'b0;
			`WAIT_FOR(o_ls_gate, 300)
			apb(1'b0, ballast_pkg::ADDR_DEADTIME, 32'h0);
			dt = rd;
			if (m == 1) `CHK(dt >= 32'hB0 && dt <= 32'hBA, 1);
			else `CHK(dt, (m == 0) ? ballast_pkg::DT_MIN_CYC : ballast_pkg::DT_MAX_CYC);
			@(posedge i_clk);
			i_ls_off_req <= 1'b1;
			@(posedge i_clk);
			i_ls_off_req <= 1'b0;
			`WAIT_FOR(!o_ls_gate, 4)
			`WAIT_FOR(o_hs_gate, 300)
			`CHK(n, dt);
		end
		@(posedge i_clk);
		i_run_freq_reached <= 1'b1;
		i_lamp_ac_over     <= 1'b1;
		`WAIT_FOR(1'b0, 80)
		`CHK(o_lamp_overvoltage_fault, 0);
		@(posedge i_clk);
		i_lamp_ac_over <= 1'b0;
		`WAIT_FOR(1'b0, 40)
		apb(1'b0, ballast_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd[ballast_pkg::ST_RUN_BIT], 1);
		@(posedge i_clk);
		i_lamp_ac_over <= 1'b1;
		repeat (LAMP_OVERVOLTAGE_FAULT) @(posedge i_clk);
		i_lamp_ac_over <= 1'b0;
		`WAIT_FOR(1'b0, 5)
		`CHK(o_lamp_overvoltage_fault, 0);
		@(posedge i_clk);
		i_lamp_ac_over <= 1'b1;
		`WAIT_FOR(o_lamp_overvoltage_fault, 40)
		`CHK(n >= 21 && n <= 23, 1);
		@(posedge i_clk);
		i_lamp_ac_over <= 1'b0;
		`WAIT_FOR(o_restart, 80)
		`CHK(n >= RST - 3 && n <= RST + 3, 1);
		`WAIT_FOR(1'b0, 130)
		@(posedge i_clk);
		i_lamp_ac_over <= 1'b1;
		`WAIT_FOR(1'b0, 30)
		@(posedge i_clk);
		i_lamp_ac_over <= 1'b0;
		apb(1'b0, ballast_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd[ballast_pkg::ST_LATCH_BIT], 1);
		`WAIT_FOR(o_restart, 80)
		`CHK(o_restart, 0);
		@(posedge i_clk);
		i_lamp_inserted <= 1'b1;
		@(posedge i_clk);
		i_lamp_inserted <= 1'b0;
		`WAIT_FOR(o_restart, 10)
		`CHK(o_restart, 1);
		// A dip shorter than the qualifying time must not latch
		`WAIT_FOR(1'b0, 130)
		@(posedge i_clk);
		i_bus_voltage_sense_below_75 <= 1'b1;
		repeat (8) @(posedge i_clk);
		i_bus_voltage_sense_below_75 <= 1'b0;
		apb(1'b0, ballast_pkg::ADDR_STATUS, 32'h0);
		`CHK(rd[ballast_pkg::ST_LATCH_BIT], 0);
		@(posedge i_clk);
		i_bus_voltage_sense_below_75 <= 1'b1;
		`WAIT_FOR(1'b0, 16)
		`CHK({o_pfc_gate, o_hs_gate, o_ls_gate}, 0);
		@(posedge i_clk);
		i_bus_voltage_sense_below_75 <= 1'b0;
		`WAIT_FOR(o_uv_short, 20)
		`CHK({o_uv_short, o_skip_preheat, o_uv_long}, 32'h6);
		`WAIT_FOR(1'b0, 130)
		`CHK(o_skip_preheat, 0);
		@(posedge i_clk);
		i_bus_voltage_sense_below_75 <= 1'b1;
		`WAIT_FOR(o_full_restart, 300)
		`CHK(n >= UVL, 1);
		`WAIT_FOR(o_uv_long, 3)
		`CHK(o_uv_long, 1);
		@(posedge i_clk);
		i_bus_voltage_sense_below_75 <= 1'b0;
		i_sys_rst                    <= 1'b1;
		@(posedge i_clk);
		@(negedge i_clk);
		`CHK({o_pready, o_uv_long, o_uv_short, o_lamp_overvoltage_fault}, 32'h8);
		@(posedge i_clk);
		i_sys_rst <= 1'b0;
		apb(1'b0, ballast_pkg::ADDR_DEADTIME, 32'h0);
		`CHK(rd, ballast_pkg::DT_MAX_CYC);
		// Rectifier effect after reset: pre-run, then the persistence time in run
		@(posedge i_clk);
		i_lamp_dc_over <= 1'b1;
		`WAIT_FOR(o_rectifier_effect_fault, 300)
		`CHK({o_capacitive_overcurrent_fault, o_rectifier_effect_fault, o_lamp_overvoltage_fault}, 32'h2);
		`CHK(n >= 195 && n <= 201, 1);
		@(posedge i_clk);
		i_lamp_dc_over <= 1'b0;
		finish_test();
	end
endmodule

`default_nettype wire
